// >>> bench/cad_link_properties.sv
/*
 Concurrent checks on the command link between reader end and tag end.
 Assumes one clock, an asynchronous active-high reset and ce held high.
*/
`timescale 1ns/1ps
module cad_link_properties
	import cad_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst,
	// Command side.
	input  wire logic       cmd_vld,
	input  wire logic [7:0] cmd_byte,
	input  wire logic       cmd_last,
	// Response side.
	input  wire logic       rsp_vld,
	input  wire logic [7:0] rsp_byte,
	input  wire logic       rsp_last
);
	// ----------------------------------------------------------------
	// Header capture
	// ----------------------------------------------------------------
	logic [8:0] idx;
	logic [7:0] cla_q;
	logic [7:0] ins_q;
	logic [7:0] p1_q;
	logic       end_c;
	logic       bad_cla;
	logic       bad_p1;
	logic       bad_mode;
	assign end_c = cmd_vld && cmd_last;
	assign bad_cla = end_c && cla_q != CAD_CLA_OK;
	assign bad_p1 = end_c && cla_q == CAD_CLA_OK &&
		ins_q == CAD_INS_READ && p1_q[7];
	assign bad_mode = end_c && cla_q == CAD_CLA_OK &&
		ins_q == CAD_INS_READ && !p1_q[7] && p1_q[5:4] == 2'h1;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			idx   <= 9'h000;
			cla_q <= 8'h00;
			ins_q <= 8'h00;
			p1_q  <= 8'h00;
		end
		else if (cmd_vld)
		begin
			idx <= cmd_last ? 9'h000 : idx + 9'h001;
			if (idx == 9'h000)
				cla_q <= cmd_byte;
			if (idx == 9'h001)
				ins_q <= cmd_byte;
			if (idx == 9'h002)
				p1_q <= cmd_byte;
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_rsp_latency: assert property (end_c |-> ##3 rsp_vld)
		else $error("response did not start three cycles after command");
	a_min_header: assert property (end_c |-> idx >= 9'h003)
		else $error("command ended before four header bytes");
	a_cla_reject: assert property (bad_cla |-> ##3
		rsp_byte == CAD_SW1_CLA ##1 rsp_byte == CAD_SW2_ZERO)
		else $error("wrong status for bad class byte");
	a_p1_bit7: assert property (bad_p1 |-> ##3
		rsp_byte == CAD_SW1_P1P2 ##1 rsp_byte == CAD_SW2_P1P2)
		else $error("wrong status for P1 top bit set");
	a_rsv_mode: assert property (bad_mode |-> ##3
		rsp_byte == CAD_SW1_P1P2 ##1 rsp_byte == CAD_SW2_P1P2)
		else $error("wrong status for reserved mode");
	a_reject_short: assert property ((bad_cla || bad_p1 || bad_mode)
		|-> ##3 !rsp_last ##1 rsp_vld && rsp_last)
		else $error("rejected command answer is not two bytes");
	a_last_has_vld: assert property (rsp_last |-> rsp_vld)
		else $error("last flag without response strobe");
	a_rsp_burst: assert property (rsp_vld && !rsp_last |=> rsp_vld)
		else $error("gap inside response");
	a_cmd_quiet: assert property (rsp_vld |-> !cmd_vld)
		else $error("command byte sent during response");
endmodule

// >>> bench/contactless_apdu_command_decoder_tb.sv
/*
 Self-checking bench: reader end and tag end joined by the link.
 Assumes the package and both design ends compile before this file.
*/
`timescale 1ns/1ps
module contactless_apdu_command_decoder_tb
	import cad_pkg::*;
;
	logic        clk;
	logic        rst;
	logic        go;
	logic [7:0]  cla, ins, p1, p2, lc, dat, le;
	logic        busy, done;
	logic [7:0]  sw1, sw2, body_cnt;
	logic [7:0]  sys_afi, reqb_afi, body;
	logic        reqb_vld, reqb_answer, cmd_ok, fwt_expired;
	logic [31:0] pupi;
	logic [3:0]  fwi;
	logic [7:0]  cmd_ins;
	logic [2:0]  cmd_mode;
	logic [11:0] cmd_addr;
	int          err_count, cmp_count, fwt_cnt, m;
	// ----------------------------------------------------------------
	// Design ends
	// ----------------------------------------------------------------
	cad_if lnk();
	cad_reader u_cad_reader (.clk(clk), .rst(rst), .ce(1'b1), .lnk(lnk),
		.go(go), .u_cla(cla), .u_ins(ins), .u_p1(p1), .u_p2(p2),
		.u_lc(lc), .u_data(dat), .u_le(le), .busy(busy), .done(done),
		.sw1(sw1), .sw2(sw2), .body_cnt(body_cnt));
	cad_tag #(.MEM_BYTES(2048), .MAX_LEN(32)) u_cad_tag (.clk(clk),
		.rst(rst), .ce(1'b1), .lnk(lnk), .sys_afi(sys_afi),
		.card_identifier_area(64'h0123456789ABCDEF), .fwi(fwi),
		.reqb_vld(reqb_vld), .reqb_afi(reqb_afi),
		.reqb_answer(reqb_answer), .pupi(pupi), .body_byte(body),
		.cmd_ok(cmd_ok), .cmd_ins(cmd_ins), .cmd_mode(cmd_mode),
		.cmd_addr(cmd_addr), .fwt_expired(fwt_expired));
	cad_link_properties u_cad_link_properties (.clk(clk), .rst(rst),
		.cmd_vld(lnk.cmd_vld), .cmd_byte(lnk.cmd_byte),
		.cmd_last(lnk.cmd_last), .rsp_vld(lnk.rsp_vld),
		.rsp_byte(lnk.rsp_byte), .rsp_last(lnk.rsp_last));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	always #25 clk = ~clk;
	always @(posedge clk)
		if (fwt_expired === 1'b1)
			fwt_cnt++;
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic afi(input logic [7:0] req, input logic exp);
		reqb_afi = req;
		reqb_vld = 1'b1;
		@(negedge clk);
		reqb_vld = 1'b0;
		chk("answer", {31'h0, reqb_answer}, {31'h0, exp});
	endtask
	task automatic run(input logic [7:0] c, i, a, b, l, e, s1, s2, n);
		int k;
		cla = c;
		ins = i;
		p1 = a;
		p2 = b;
		lc = l;
		le = e;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		for (k = 0; k < 800 && done !== 1'b1; k++)
			@(posedge clk) #1;
		chk("sw1", {24'h0, sw1}, {24'h0, s1});
		chk("sw2", {24'h0, sw2}, {24'h0, s2});
		chk("body", {24'h0, body_cnt}, {24'h0, n});
		chk("done", {31'h0, done}, 32'h1);
		chk("ins", {24'h0, cmd_ins}, {24'h0, i});
		chk("ok", {31'h0, cmd_ok}, {31'h0, s1 == 8'h90});
		@(negedge clk);
	endtask
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		#(40000 * 50);
		err_count++;
		final_report;
	end
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		go = 1'b0;
		{cla, ins, p1, p2, lc, le} = 48'h0;
		dat = 8'h3C;
		body = 8'h5A;
		fwi = 4'h0;
		sys_afi = 8'h35;
		reqb_vld = 1'b0;
		reqb_afi = 8'h00;
		{err_count, cmp_count, fwt_cnt} = '0;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		afi(8'h00, 1'b1);
		afi(8'h30, 1'b1);
		afi(8'h40, 1'b0);
		afi(8'h05, 1'b1);
		afi(8'h06, 1'b0);
		afi(8'h35, 1'b1);
		afi(8'h36, 1'b0);
		chk("pupi", pupi, 32'h89ABCDEF);
		run(8'h00, 8'hA4, 8'h00, 8'h00, 8'h00, 8'h00, 8'h90, 8'h00, 8'h00);
		run(8'h00, 8'hA4, 8'h01, 8'h00, 8'h00, 8'h00, 8'h6A, 8'h86, 8'h00);
		run(8'h80, 8'hB0, 8'h00, 8'h00, 8'h00, 8'h04, 8'h6E, 8'h00, 8'h00);
		run(8'h00, 8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h6D, 8'h00, 8'h00);
		run(8'h00, 8'hB0, 8'h01, 8'h23, 8'h00, 8'h04, 8'h90, 8'h00, 8'h04);
		chk("addr", {20'h0, cmd_addr}, 32'h123);
		run(8'h00, 8'hB0, 8'h80, 8'h10, 8'h00, 8'h10, 8'h6A, 8'h86, 8'h00);
		run(8'h00, 8'hB0, 8'h08, 8'h00, 8'h00, 8'h04, 8'h6A, 8'h86, 8'h00);
		run(8'h00, 8'hB0, 8'h20, 8'h21, 8'h00, 8'h10, 8'h6A, 8'h86, 8'h00);
		run(8'h00, 8'hB0, 8'h20, 8'h20, 8'h00, 8'h05, 8'h67, 8'h00, 8'h00);
		run(8'h00, 8'hB0, 8'h00, 8'h00, 8'h00, 8'h21, 8'h67, 8'h00, 8'h00);
		run(8'h00, 8'hD6, 8'h00, 8'h00, 8'h00, 8'h00, 8'h67, 8'h00, 8'h00);
		run(8'h00, 8'hD6, 8'h00, 8'h40, 8'h02, 8'h00, 8'h90, 8'h00, 8'h00);
		for (m = 0; m < 8; m++)
		begin
			if (m[1:0] == 2'h1)
				run(8'h00, 8'hB0, 8'(m << 4), 8'h10, 8'h00, 8'h10, 8'h6A, 8'h86, 8'h00);
			else
			begin
				run(8'h00, 8'hB0, 8'(m << 4), 8'h10, 8'h00, 8'h10, 8'h90, 8'h00, 8'h10);
				chk("mode", {29'h0, cmd_mode}, 32'(m));
			end
		end
		chk("fwt", fwt_cnt, 32'h0);
		final_report;
	end
endmodule

// >>> rtl/cad_afi_match.sv
/*
 Family value filter for request frames.
 Assumes both inputs are stable while sampled.
*/
`timescale 1ns/1ps
module cad_afi_match
	import cad_pkg::*;
(
	// Values.
	input  wire logic [7:0] req_afi,
	input  wire logic [7:0] sys_afi,
	// Result.
	output logic            answer
);
	always_comb
	begin
		if (req_afi == CAD_BYTE_ZERO)
			answer = 1'b1;
		else if (req_afi[3:0] == CAD_NIB_ZERO)
			answer = req_afi[7:4] == sys_afi[7:4];
		else if (req_afi[7:4] == CAD_NIB_ZERO)
			answer = req_afi[3:0] == sys_afi[3:0];
		else
			answer = req_afi == sys_afi;
	end
endmodule

// >>> rtl/cad_if.sv
/*
 Byte link between reader end and tag end; each byte is a one-cycle
 strobe, each APDU ends with a last flag.
 Assumes one shared clock.
*/
`timescale 1ns/1ps
interface cad_if;
	logic       cmd_vld;
	logic [7:0] cmd_byte;
	logic       cmd_last;
	logic       rsp_vld;
	logic [7:0] rsp_byte;
	logic       rsp_last;
	modport tag
	(
		input  cmd_vld, cmd_byte, cmd_last,
		output rsp_vld, rsp_byte, rsp_last
	);
	modport reader
	(
		output cmd_vld, cmd_byte, cmd_last,
		input  rsp_vld, rsp_byte, rsp_last
	);
endinterface

// >>> rtl/cad_pkg.sv
/*
 Constants, types and field layouts shared by both ends of the
 application command link of a contactless tag.
 Assumes both ends run on one clock at 20 MHz with a common reset.
*/
package cad_pkg;
	localparam logic [7:0] CAD_CLA_OK      = 8'h00;
	localparam logic [7:0] CAD_INS_SELECT  = 8'hA4;
	localparam logic [7:0] CAD_INS_READ    = 8'hB0;
	localparam logic [7:0] CAD_INS_WRITE   = 8'hD6;
	localparam logic [7:0] CAD_SW1_OK      = 8'h90;
	localparam logic [7:0] CAD_SW2_OK      = 8'h00;
	localparam logic [7:0] CAD_SW1_P1P2    = 8'h6A;
	localparam logic [7:0] CAD_SW2_P1P2    = 8'h86;
	localparam logic [7:0] CAD_SW1_CLA     = 8'h6E;
	localparam logic [7:0] CAD_SW1_LEN     = 8'h67;
	localparam logic [7:0] CAD_SW1_INS     = 8'h6D;
	localparam logic [7:0] CAD_SW2_ZERO    = 8'h00;
	localparam logic [7:0] CAD_SEL_P1      = 8'h00;
	localparam logic [7:0] CAD_SEL_P2      = 8'h00;
	localparam int         CAD_P1_RSV_BIT  = 7;
	localparam int         CAD_MODE_HI     = 6;
	localparam int         CAD_MODE_LO     = 4;
	localparam logic [3:0] CAD_ALIGN_MASK  = 4'hF;
	localparam logic [7:0] CAD_BYTE_ZERO   = 8'h00;
	localparam logic [3:0] CAD_NIB_ZERO    = 4'h0;
	localparam int         CAD_ADDR_W      = 12;
	localparam int         CAD_FWI_MAX     = 14;
	localparam int         CAD_CLK_HZ      = 20000000;
	localparam longint     CAD_FC_HZ       = 64'd13560000;
	localparam longint     CAD_T_CARRIER   = 64'd4096;
	// Cycles of T, rounded down since T bounds a longest wait.
	localparam int CAD_T_CYC =
		int'((CAD_T_CARRIER * CAD_CLK_HZ) / CAD_FC_HZ);

	typedef enum logic [2:0] {
		CAD_M_RF_PLAIN  = 3'h0,
		CAD_M_RSV_A     = 3'h1,
		CAD_M_RF_PRIV   = 3'h2,
		CAD_M_RF_FAM    = 3'h3,
		CAD_M_TN_PLAIN  = 3'h4,
		CAD_M_RSV_B     = 3'h5,
		CAD_M_TN_PRIV   = 3'h6,
		CAD_M_TN_FAM    = 3'h7
	} cad_mode_t;
endpackage

// >>> rtl/cad_reader.sv
/*
 Reader end: serialises one command APDU onto the link and gathers
 the response, keeping the last two bytes as the status word.
 Assumes the user holds the command fields stable while busy.
*/
`timescale 1ns/1ps
module cad_reader
	import cad_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// Link.
	cad_if.reader           lnk,
	// User command.
	input  wire logic       go,
	input  wire logic [7:0] u_cla,
	input  wire logic [7:0] u_ins,
	input  wire logic [7:0] u_p1,
	input  wire logic [7:0] u_p2,
	input  wire logic [7:0] u_lc,
	input  wire logic [7:0] u_data,
	input  wire logic [7:0] u_le,
	// User result.
	output logic            busy,
	output logic            done,
	output logic [7:0]      sw1,
	output logic [7:0]      sw2,
	output logic [7:0]      body_cnt
);
	typedef enum logic [2:0] {
		R_IDLE, R_HDR, R_LC, R_DATA, R_LE, R_RSP
	} cad_rst_t;

	typedef struct packed {
		cad_rst_t   st;
		logic [1:0] idx;
		logic [7:0] cnt;
		logic       vld;
		logic [7:0] byt;
		logic       last;
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] rx;
		logic       busy;
		logic       done;
		logic [7:0] sw1;
		logic [7:0] sw2;
		logic [7:0] body_cnt;
	} cad_rstate_t;

	cad_rstate_t q;
	cad_rstate_t d;

	always_comb
	begin
		d = q;
		d.vld = 1'b0;
		d.last = 1'b0;
		d.done = 1'b0;
		unique case (q.st)
			R_IDLE:
				if (go)
				begin
					d.st = R_HDR;
					d.idx = 2'd0;
					d.busy = 1'b1;
					d.rx = CAD_BYTE_ZERO;
				end
			R_HDR:
			begin
				d.vld = 1'b1;
				unique case (q.idx)
					2'd0: d.byt = u_cla;
					2'd1: d.byt = u_ins;
					2'd2: d.byt = u_p1;
					default: d.byt = u_p2;
				endcase
				d.idx = q.idx + 2'd1;
				if (q.idx == 2'd3)
				begin
					d.st = u_lc != CAD_BYTE_ZERO ? R_LC :
						(u_le != CAD_BYTE_ZERO ? R_LE : R_RSP);
					d.last = u_lc == CAD_BYTE_ZERO &&
						u_le == CAD_BYTE_ZERO;
				end
			end
			R_LC:
			begin
				d.vld = 1'b1;
				d.byt = u_lc;
				d.cnt = u_lc;
				d.st = R_DATA;
			end
			R_DATA:
			begin
				d.vld = 1'b1;
				d.byt = u_data;
				d.cnt = q.cnt - 8'd1;
				if (q.cnt == 8'd1)
				begin
					d.st = u_le != CAD_BYTE_ZERO ? R_LE : R_RSP;
					d.last = u_le == CAD_BYTE_ZERO;
				end
			end
			R_LE:
			begin
				d.vld = 1'b1;
				d.byt = u_le;
				d.last = 1'b1;
				d.st = R_RSP;
			end
			R_RSP:
			begin
				d.rx = CAD_BYTE_ZERO;
				if (lnk.rsp_vld)
				begin
					d.b0 = q.b1;
					d.b1 = lnk.rsp_byte;
					d.rx = q.rx + 8'd1;
					if (lnk.rsp_last)
					begin
						d.sw1 = q.b1;
						d.sw2 = lnk.rsp_byte;
						d.body_cnt = q.rx - 8'd1;
						d.done = 1'b1;
						d.busy = 1'b0;
						d.st = R_IDLE;
					end
				end
				else
					d.rx = q.rx;
			end
			default: d.st = R_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q <= '0;
			q.st <= R_IDLE;
		end
		else if (ce)
			q <= d;
	end

	assign lnk.cmd_vld = q.vld;
	assign lnk.cmd_byte = q.byt;
	assign lnk.cmd_last = q.last;
	assign busy = q.busy;
	assign done = q.done;
	assign sw1 = q.sw1;
	assign sw2 = q.sw2;
	assign body_cnt = q.body_cnt;
endmodule

// >>> rtl/cad_tag.sv
/*
 Tag end: parses command APDUs out of block payloads, checks class,
 parameters and lengths, answers status-only or data plus status.
 Assumes framing below this block delivers payload bytes with a last
 flag, and that data bodies and cipher work happen elsewhere.
*/
`timescale 1ns/1ps
module cad_tag
	import cad_pkg::*;
#(
	parameter int MEM_BYTES = 4096,
	parameter int MAX_LEN   = 255
)
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Link.
	cad_if.tag               lnk,
	// System area.
	input  wire logic [7:0]  sys_afi,
	input  wire logic [63:0] card_identifier_area,
	input  wire logic [3:0]  fwi,
	// Request filter.
	input  wire logic        reqb_vld,
	input  wire logic [7:0]  reqb_afi,
	output logic             reqb_answer,
	output logic [31:0]      pupi,
	// Response data supply.
	input  wire logic [7:0]  body_byte,
	// Decoded command.
	output logic             cmd_ok,
	output logic [7:0]       cmd_ins,
	output logic [2:0]       cmd_mode,
	output logic [11:0]      cmd_addr,
	output logic             fwt_expired
);
	initial
	begin
		if (MEM_BYTES < 1 || MEM_BYTES > (1 << CAD_ADDR_W))
			$error("MEM_BYTES out of range");
		if (MAX_LEN < 1 || MAX_LEN > 255)
			$error("MAX_LEN out of range");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		S_CLA, S_INS, S_P1, S_P2, S_LEN, S_DATA, S_BODY, S_SW
	} cad_tst_t;

	typedef struct packed {
		cad_tst_t    st;
		logic [7:0]  cla;
		logic [7:0]  ins;
		logic [7:0]  p1;
		logic [7:0]  p2;
		logic [7:0]  len1;
		logic        has_len1;
		logic [7:0]  le;
		logic        has_le;
		logic [7:0]  cnt;
		logic [7:0]  sw1;
		logic [7:0]  sw2;
		logic        sw_second;
		logic        rsp_vld;
		logic [7:0]  rsp_byte;
		logic        rsp_last;
		logic        reqb_answer;
		logic [31:0] pupi;
		logic        cmd_ok;
		logic [2:0]  mode;
		logic [11:0] addr;
		logic [31:0] wait_cnt;
		logic        waiting;
		logic        fwt_expired;
	} cad_tstate_t;

	cad_tstate_t q;
	cad_tstate_t d;
	logic        afi_hit;

	cad_afi_match u_afi
	(
		.req_afi (reqb_afi),
		.sys_afi (sys_afi),
		.answer  (afi_hit)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic        enc;
		logic [11:0] a;
		logic [7:0]  dlen;
		logic [7:0]  elen;
		logic        has_data;
		logic [31:0] fwt_lim;
		d = q;
		d.rsp_vld = 1'b0;
		d.rsp_last = 1'b0;
		d.fwt_expired = 1'b0;
		a = {q.p1[3:0], q.p2};
		enc = q.p1[5];
		// A lone length byte after the header is taken as Le.
		has_data = q.has_len1 && q.cnt != CAD_BYTE_ZERO;
		dlen = has_data ? q.len1 : CAD_BYTE_ZERO;
		elen = q.has_le ? q.le :
			(q.has_len1 && !has_data ? q.len1 : CAD_BYTE_ZERO);
		fwt_lim = CAD_T_CYC << ((fwi > 4'(CAD_FWI_MAX)) ?
			4'(CAD_FWI_MAX) : fwi);
		if (reqb_vld)
		begin
			d.reqb_answer = afi_hit;
			d.pupi = card_identifier_area[31:0];
		end
		if (q.waiting)
		begin
			d.wait_cnt = q.wait_cnt + 32'd1;
			if (q.wait_cnt + 32'd1 >= fwt_lim)
			begin
				d.fwt_expired = 1'b1;
				d.waiting = 1'b0;
			end
		end
		unique case (q.st)
			S_CLA, S_INS, S_P1, S_P2, S_LEN, S_DATA:
			begin
				if (lnk.cmd_vld)
				begin
					unique case (q.st)
						S_CLA: d.cla = lnk.cmd_byte;
						S_INS: d.ins = lnk.cmd_byte;
						S_P1:  d.p1 = lnk.cmd_byte;
						S_P2:  d.p2 = lnk.cmd_byte;
						S_LEN:
						begin
							d.len1 = lnk.cmd_byte;
							d.has_len1 = 1'b1;
							d.cnt = CAD_BYTE_ZERO;
						end
						default:
						begin
							if (q.cnt == q.len1)
							begin
								d.le = lnk.cmd_byte;
								d.has_le = 1'b1;
							end
							else
								d.cnt = q.cnt + 8'd1;
						end
					endcase
					if (q.st == S_P2 || q.st == S_LEN ||
						q.st == S_DATA)
					begin
						if (q.st == S_P2)
							d.st = S_LEN;
						if (q.st == S_LEN)
							d.st = S_DATA;
					end
					else
						d.st = cad_tst_t'(q.st + 3'd1);
					if (lnk.cmd_last)
					begin
						d.st = S_SW;
						d.sw_second = 1'b0;
						d.waiting = 1'b1;
						d.wait_cnt = '0;
					end
				end
			end
			S_BODY:
			begin
				d.waiting = 1'b0;
				d.rsp_vld = 1'b1;
				d.rsp_byte = body_byte;
				d.cnt = q.cnt - 8'd1;
				if (q.cnt == 8'd1)
				begin
					d.st = S_SW;
					d.sw_second = 1'b1;
				end
			end
			S_SW:
			begin
				d.waiting = 1'b0;
				d.rsp_vld = 1'b1;
				if (!q.sw_second)
				begin
					d.cmd_ok = 1'b0;
					d.mode = q.p1[CAD_MODE_HI:CAD_MODE_LO];
					d.addr = a;
					d.sw1 = CAD_SW1_OK;
					d.sw2 = CAD_SW2_OK;
					if (q.cla != CAD_CLA_OK)
					begin
						d.sw1 = CAD_SW1_CLA;
						d.sw2 = CAD_SW2_ZERO;
					end
					else if (q.ins == CAD_INS_SELECT)
					begin
						if (q.p1 != CAD_SEL_P1 || q.p2 != CAD_SEL_P2)
						begin
							d.sw1 = CAD_SW1_P1P2;
							d.sw2 = CAD_SW2_P1P2;
						end
						else
							d.cmd_ok = 1'b1;
					end
					else if (q.ins != CAD_INS_READ &&
						q.ins != CAD_INS_WRITE)
					begin
						d.sw1 = CAD_SW1_INS;
						d.sw2 = CAD_SW2_ZERO;
					end
					else if (q.p1[CAD_P1_RSV_BIT] ||
						q.p1[CAD_MODE_LO] && !enc ||
						32'(a) >= 32'(MEM_BYTES) ||
						enc && (a[3:0] & CAD_ALIGN_MASK) != 4'h0)
					begin
						d.sw1 = CAD_SW1_P1P2;
						d.sw2 = CAD_SW2_P1P2;
					end
					else if (32'(dlen) > 32'(MAX_LEN) ||
						32'(elen) > 32'(MAX_LEN) ||
						(q.ins == CAD_INS_WRITE) != has_data ||
						enc && ((dlen | elen) & 8'h0F) != 8'h00)
					begin
						d.sw1 = CAD_SW1_LEN;
						d.sw2 = CAD_SW2_ZERO;
					end
					else
						d.cmd_ok = 1'b1;
					d.rsp_vld = 1'b0;
					d.sw_second = 1'b1;
					d.cnt = CAD_BYTE_ZERO;
					if (d.sw1 == CAD_SW1_OK &&
						q.ins == CAD_INS_READ && elen != 8'h00)
					begin
						d.st = S_BODY;
						d.cnt = elen;
					end
				end
				else
				begin
					// Status-only unless an accepted read with nonzero Le, then after body.
					d.rsp_byte = q.sw1;
					d.cnt = 8'hFF;
					if (q.cnt == 8'hFF)
					begin
						d.rsp_byte = q.sw2;
						d.rsp_last = 1'b1;
						d.st = S_CLA;
						d.has_len1 = 1'b0;
						d.has_le = 1'b0;
						d.cnt = CAD_BYTE_ZERO;
					end
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q <= '0;
			q.st <= S_CLA;
		end
		else if (ce)
			q <= d;
	end

	assign lnk.rsp_vld = q.rsp_vld;
	assign lnk.rsp_byte = q.rsp_byte;
	assign lnk.rsp_last = q.rsp_last;
	assign reqb_answer = q.reqb_answer;
	assign pupi = q.pupi;
	assign cmd_ok = q.cmd_ok;
	assign cmd_ins = q.ins;
	assign cmd_mode = q.mode;
	assign cmd_addr = q.addr;
	assign fwt_expired = q.fwt_expired;
endmodule
